/* design/flash_regs_pkg.sv */
// constants, field layouts and timing figures of the flash led driver register bank
// assumes a 10 mhz system clock and a byte-level serial link engine on its own clock
//
// Behaviour
// - The upper five bits of register 0 hold the main current code: zero is off, 1 to 11 are torch levels.
// - Main codes 12 to 31 arm the flash at that level, and it fires on the trigger bit or the strobe, even one set before arming.
// - The low three bits of register 0 hold the indicator code: 0 off, 001 2.5 mA, 011 5 mA, 111 17.5 mA.
// - Bit 4 of register 1 picks the protective time-out limit (0) or timed flash of the coded duration (1).
// - Status bit 3 reads 1 while the led output is shorted to ground, resets to 0 and ignores writes.
// - Status bit 2 reads 1 while overtemperature protection is triggered, resets to 0 and ignores writes.
// - Status bit 1 sets when a flash outlasts its time-out, resets to 0 and ignores writes.
// - The low four bits of register 1 give the flash duration, 820 ms at code 0 down to 1 ms at code 15.
// - When the strobe falls and ends the flash, the trigger bit is cleared back to zero.
// - Status bit 0 sets on overvoltage and converter switching is inhibited meanwhile.
// - The register pointer advances by one after each data byte on the link.
package flash_regs_pkg;

    localparam logic [7:0] addr_led_current   = 8'h00;
    localparam logic [7:0] addr_flash_timer   = 8'h01;
    localparam logic [7:0] addr_flash_trigger = 8'h02;
    localparam logic [7:0] addr_fault_status  = 8'h03;

    localparam logic [7:0] reset_value        = 8'h00;
    localparam logic [4:0] main_off           = 5'h00;
    localparam logic [4:0] torch_last         = 5'h0b;
    localparam logic [4:0] flash_first        = 5'h0c;
    localparam int         main_lsb           = 3;
    localparam int         policy_bit         = 4;
    localparam int         trigger_bit        = 0;
    localparam int         short_bit          = 3;
    localparam int         overheat_bit       = 2;
    localparam int         timeout_bit        = 1;
    localparam int         overvoltage_bit    = 0;
    localparam logic [7:0] timer_mask         = 8'h1f;
    localparam logic [7:0] trigger_mask       = 8'h01;

    localparam int clk_mhz      = 10;
    localparam int us_per_ms    = 1000;
    localparam int clk_per_ms   = clk_mhz * us_per_ms;
    localparam int ms_width     = 10;

    // flash duration in ms per code; middle codes are a linear fill
    function automatic logic [9:0] duration_ms(input logic [3:0] code);
        logic [9:0] ms;
        ms = 10'h000;
        case (code)
            4'h0:    ms = 10'h334;
            4'h1:    ms = 10'h2fd;
            4'h2:    ms = 10'h2c6;
            4'h3:    ms = 10'h28f;
            4'h4:    ms = 10'h258;
            4'h5:    ms = 10'h221;
            4'h6:    ms = 10'h1ea;
            4'h7:    ms = 10'h1b3;
            4'h8:    ms = 10'h17c;
            4'h9:    ms = 10'h145;
            4'ha:    ms = 10'h10e;
            4'hb:    ms = 10'h0d7;
            4'hc:    ms = 10'h0a0;
            4'hd:    ms = 10'h06c;
            4'he:    ms = 10'h038;
            default: ms = 10'h001;
        endcase
        return ms;
    endfunction

    typedef enum {link_idle, link_wait} link_state_t;

endpackage

/* design/sync_bits.sv */
// two-flop synchroniser for a group of independent levels
// assumes each bit is a level or toggle that changes no faster than the destination clock
`timescale 1ns/1ns
`default_nettype none
module sync_bits #(
    parameter int width = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic [width-1:0] din,
    output logic      [width-1:0] dout
);
    logic [width-1:0] stage1;
    logic [width-1:0] next_stage1;
    logic [width-1:0] next_dout;

    always_comb
    begin
        next_stage1 = din;
        next_dout   = stage1;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage1 <= '0;
            dout   <= '0;
        end
        else
        begin
            stage1 <= next_stage1;
            dout   <= next_dout;
        end
    end
endmodule // sync_bits
`default_nettype wire

/* design/flash_led_driver_register_bank.sv */
// register bank and flash timing of the photo-flash led driver
// assumes a link engine on link_clk delivering acknowledged bytes; analog detectors are async levels
`timescale 1ns/1ns
`default_nettype none
module flash_led_driver_register_bank #(
    parameter int clk_per_ms = flash_regs_pkg::clk_per_ms
) (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       link_clk,
    input  wire logic       link_sub_valid,
    input  wire logic       link_wr_valid,
    input  wire logic       link_rd_req,
    input  wire logic [7:0] link_byte,
    output logic      [7:0] link_rd_data,
    output logic            link_rd_valid,
    output logic            link_busy,
    input  wire logic       strobe_pin,
    input  wire logic       short_detect,
    input  wire logic       overheat_detect,
    input  wire logic       overvoltage_detect,
    output logic      [4:0] main_current_code,
    output logic      [2:0] indicator_current_code,
    output logic            torch_on,
    output logic            flash_armed,
    output logic            flash_on,
    output logic            converter_inhibit
);

    ////////////////////////////////////////
    // link domain: pointer and request toggle

    flash_regs_pkg::link_state_t state;
    flash_regs_pkg::link_state_t next_state;
    logic [7:0] pointer;
    logic [7:0] next_pointer;
    logic       req_toggle;
    logic       next_req_toggle;
    logic       req_write;
    logic       next_req_write;
    logic [7:0] req_addr;
    logic [7:0] next_req_addr;
    logic [7:0] req_data;
    logic [7:0] next_req_data;
    logic       ack_seen;
    logic       next_ack_seen;
    logic       ack_link;
    logic       ack_toggle;
    logic [7:0] next_link_rd_data;
    logic       next_link_rd_valid;
    logic       next_link_busy;
    logic [7:0] read_hold;

    // read_hold is stable while link_wait, so sampling it after the ack is safe
    sync_bits #(.width(1)) ack_sync (
        .clk   (link_clk),
        .rst_b (rst_b),
        .din   (ack_toggle),
        .dout  (ack_link)
    );

    always_comb
    begin
        next_state         = state;
        next_pointer       = pointer;
        next_req_toggle    = req_toggle;
        next_req_write     = req_write;
        next_req_addr      = req_addr;
        next_req_data      = req_data;
        next_ack_seen      = ack_seen;
        next_link_rd_data  = link_rd_data;
        next_link_rd_valid = 1'b0;
        case (state)
            flash_regs_pkg::link_idle:
            begin
                if (link_sub_valid)
                    next_pointer = link_byte;
                else if (link_wr_valid || link_rd_req)
                begin
                    next_req_write  = link_wr_valid;
                    next_req_addr   = pointer;
                    next_req_data   = link_byte;
                    next_req_toggle = !req_toggle;
                    next_state      = flash_regs_pkg::link_wait;
                end
            end
            flash_regs_pkg::link_wait:
            begin
                if (ack_link != ack_seen)
                begin
                    next_ack_seen      = ack_link;
                    next_pointer       = pointer + 8'h01;
                    next_link_rd_data  = req_write ? link_rd_data : read_hold;
                    next_link_rd_valid = !req_write;
                    next_state         = flash_regs_pkg::link_idle;
                end
            end
            default: next_state = flash_regs_pkg::link_idle;
        endcase
        next_link_busy = (next_state == flash_regs_pkg::link_wait);
    end

    always_ff @(posedge link_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state         <= flash_regs_pkg::link_idle;
            pointer       <= flash_regs_pkg::reset_value;
            req_toggle    <= 1'b0;
            req_write     <= 1'b0;
            req_addr      <= flash_regs_pkg::reset_value;
            req_data      <= flash_regs_pkg::reset_value;
            ack_seen      <= 1'b0;
            link_rd_data  <= flash_regs_pkg::reset_value;
            link_rd_valid <= 1'b0;
            link_busy     <= 1'b0;
        end
        else
        begin
            state         <= next_state;
            pointer       <= next_pointer;
            req_toggle    <= next_req_toggle;
            req_write     <= next_req_write;
            req_addr      <= next_req_addr;
            req_data      <= next_req_data;
            ack_seen      <= next_ack_seen;
            link_rd_data  <= next_link_rd_data;
            link_rd_valid <= next_link_rd_valid;
            link_busy     <= next_link_busy;
        end
    end

    ////////////////////////////////////////
    // system domain: registers, flash timer, protection

    logic [4:0] pins;
    logic       req_sys;
    logic       req_prev;
    logic       next_req_prev;
    logic       next_ack_toggle;
    logic [7:0] next_read_hold;
    logic [7:0] led_current_control;
    logic [7:0] next_led_current_control;
    logic [7:0] flash_timer_control;
    logic [7:0] next_flash_timer_control;
    logic       flash_trigger_bit;
    logic       next_flash_trigger_bit;
    logic       timeout_fault_flag;
    logic       next_timeout_fault_flag;
    logic       strobe_prev;
    logic       next_strobe_prev;
    logic       spent;
    logic       next_spent;
    logic [31:0] prescale;
    logic [31:0] next_prescale;
    logic [flash_regs_pkg::ms_width-1:0] ms_count;
    logic [flash_regs_pkg::ms_width-1:0] next_ms_count;
    logic [7:0] fault_status;
    logic [flash_regs_pkg::ms_width-1:0] limit;
    logic       next_flash_on;
    logic       want_flash;
    logic       armed;
    logic       strobe_level;
    logic       short_fault_flag;
    logic       overheat_flag;
    logic       overvoltage_flag;

    sync_bits #(.width(5)) pin_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   ({req_toggle, strobe_pin, short_detect, overheat_detect, overvoltage_detect}),
        .dout  (pins)
    );

    always_comb
    begin
        req_sys          = pins[4];
        strobe_level     = pins[3];
        short_fault_flag = pins[2];
        overheat_flag    = pins[1];
        overvoltage_flag = pins[0];
        fault_status     = flash_regs_pkg::reset_value;
        fault_status[flash_regs_pkg::short_bit]       = short_fault_flag;
        fault_status[flash_regs_pkg::overheat_bit]    = overheat_flag;
        fault_status[flash_regs_pkg::timeout_bit]     = timeout_fault_flag;
        fault_status[flash_regs_pkg::overvoltage_bit] = overvoltage_flag;
        armed = led_current_control[7:flash_regs_pkg::main_lsb]
                >= flash_regs_pkg::flash_first;
        // time-out policy always uses the code-0 limit
        limit = flash_timer_control[flash_regs_pkg::policy_bit]
                ? flash_regs_pkg::duration_ms(flash_timer_control[3:0])
                : flash_regs_pkg::duration_ms(4'h0);

        next_req_prev            = req_sys;
        next_ack_toggle          = ack_toggle;
        next_read_hold           = read_hold;
        next_led_current_control = led_current_control;
        next_flash_timer_control = flash_timer_control;
        next_flash_trigger_bit   = flash_trigger_bit;
        next_timeout_fault_flag  = timeout_fault_flag;
        next_strobe_prev         = strobe_level;
        next_spent               = spent;
        next_prescale            = prescale;
        next_ms_count            = ms_count;
        next_flash_on            = flash_on;

        if (req_sys != req_prev)
        begin
            next_ack_toggle = !ack_toggle;
            if (req_write)
            begin
                case (req_addr)
                    flash_regs_pkg::addr_led_current:
                        next_led_current_control = req_data;
                    flash_regs_pkg::addr_flash_timer:
                        next_flash_timer_control = req_data & flash_regs_pkg::timer_mask;
                    flash_regs_pkg::addr_flash_trigger:
                        next_flash_trigger_bit = req_data[flash_regs_pkg::trigger_bit];
                    default: ;  // status and unmapped writes are dropped
                endcase
            end
            else
            begin
                case (req_addr)
                    flash_regs_pkg::addr_led_current:   next_read_hold = led_current_control;
                    flash_regs_pkg::addr_flash_timer:   next_read_hold = flash_timer_control;
                    flash_regs_pkg::addr_flash_trigger:
                        next_read_hold = {7'h00, flash_trigger_bit};
                    flash_regs_pkg::addr_fault_status:  next_read_hold = fault_status;
                    default:                            next_read_hold = flash_regs_pkg::reset_value;
                endcase
            end
        end

        want_flash = armed && (flash_trigger_bit || strobe_level);
        if (!flash_on)
        begin
            // spent blocks a refire until trigger and strobe both drop or the main code disarms
            if (!want_flash)
                next_spent = 1'b0;
            else if (!spent)
            begin
                next_flash_on           = 1'b1;
                next_timeout_fault_flag = 1'b0;
                next_prescale           = '0;
                next_ms_count           = '0;
            end
        end
        else if (strobe_prev && !strobe_level && !flash_trigger_bit)
        begin
            next_flash_on          = 1'b0;
            next_flash_trigger_bit = 1'b0;
        end
        else if (!want_flash)
            next_flash_on = 1'b0;
        else if (ms_count >= limit)
        begin
            next_flash_on          = 1'b0;
            next_spent             = 1'b1;
            next_flash_trigger_bit = 1'b0;
            if (!flash_timer_control[flash_regs_pkg::policy_bit])
                next_timeout_fault_flag = 1'b1;
        end
        else if (prescale == 32'(clk_per_ms - 1))
        begin
            next_prescale = '0;
            next_ms_count = ms_count + 1'b1;
        end
        else
            next_prescale = prescale + 32'h0000_0001;
        if (strobe_prev && !strobe_level)
            next_flash_trigger_bit = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            req_prev            <= 1'b0;
            ack_toggle          <= 1'b0;
            read_hold           <= flash_regs_pkg::reset_value;
            led_current_control <= flash_regs_pkg::reset_value;
            flash_timer_control <= flash_regs_pkg::reset_value;
            flash_trigger_bit   <= 1'b0;
            timeout_fault_flag  <= 1'b0;
            strobe_prev         <= 1'b0;
            spent               <= 1'b0;
            prescale            <= '0;
            ms_count            <= '0;
            flash_on            <= 1'b0;
        end
        else
        begin
            req_prev            <= next_req_prev;
            ack_toggle          <= next_ack_toggle;
            read_hold           <= next_read_hold;
            led_current_control <= next_led_current_control;
            flash_timer_control <= next_flash_timer_control;
            flash_trigger_bit   <= next_flash_trigger_bit;
            timeout_fault_flag  <= next_timeout_fault_flag;
            strobe_prev         <= next_strobe_prev;
            spent               <= next_spent;
            prescale            <= next_prescale;
            ms_count            <= next_ms_count;
            flash_on            <= next_flash_on;
        end
    end

    ////////////////////////////////////////
    // registered outputs toward the power stage

    logic [4:0] next_main_current_code;
    logic [2:0] next_indicator_current_code;
    logic       next_torch_on;
    logic       next_flash_armed;
    logic       next_converter_inhibit;

    always_comb
    begin
        next_main_current_code      = led_current_control[7:flash_regs_pkg::main_lsb];
        next_indicator_current_code = led_current_control[2:0];
        next_torch_on    = (next_main_current_code != flash_regs_pkg::main_off)
                           && (next_main_current_code <= flash_regs_pkg::torch_last);
        next_flash_armed = armed;
        next_converter_inhibit = overvoltage_flag || overheat_flag
                                 || short_fault_flag;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            main_current_code      <= flash_regs_pkg::main_off;
            indicator_current_code <= 3'h0;
            torch_on               <= 1'b0;
            flash_armed            <= 1'b0;
            converter_inhibit      <= 1'b0;
        end
        else
        begin
            main_current_code      <= next_main_current_code;
            indicator_current_code <= next_indicator_current_code;
            torch_on               <= next_torch_on;
            flash_armed            <= next_flash_armed;
            converter_inhibit      <= next_converter_inhibit;
        end
    end

endmodule // flash_led_driver_register_bank
`default_nettype wire

/* tb/flash_regs_asserts.sv */
// checker for the flash register bank, bound to its top module
// assumes the bank's own ports only; link and system clocks are unrelated
`timescale 1ns/1ns
`default_nettype none
module flash_regs_asserts #(
    parameter int clk_per_ms = flash_regs_pkg::clk_per_ms
) (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       link_clk,
    input wire logic       link_wr_valid,
    input wire logic       link_rd_valid,
    input wire logic       link_busy,
    input wire logic       strobe_pin,
    input wire logic       short_detect,
    input wire logic       overheat_detect,
    input wire logic       overvoltage_detect,
    input wire logic [4:0] main_current_code,
    input wire logic       torch_on,
    input wire logic       flash_armed,
    input wire logic       flash_on,
    input wire logic       converter_inhibit
);
    ////////////////////////////////////////
    // longest flash: 820 ms plus two ms of counter slack and sync margin
    localparam int run_cap = 822 * clk_per_ms;
    int flash_run;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            flash_run <= 0;
        else
            flash_run <= flash_on ? flash_run + 1 : 0;
    end
    ////////////////////////////////////////
    chk_torch_decode:
    assert property (@(posedge clk) disable iff (!rst_b)
        torch_on == (main_current_code >= 5'h01 && main_current_code <= 5'h0b))
        else $error("torch flag disagrees with main code");
    chk_armed_decode:
    assert property (@(posedge clk) disable iff (!rst_b)
        flash_armed == (main_current_code >= 5'h0c))
        else $error("armed flag disagrees with main code");
    chk_fire_needs_arm:
    assert property (@(posedge clk) disable iff (!rst_b) $rose(flash_on) |-> flash_armed)
        else $error("flash started while not armed");
    chk_inhibit_on_ovp:
    assert property (@(posedge clk) disable iff (!rst_b)
        overvoltage_detect [*4] |-> converter_inhibit)
        else $error("overvoltage did not inhibit converter");
    chk_inhibit_clear:
    assert property (@(posedge clk) disable iff (!rst_b)
        (!overvoltage_detect && !overheat_detect && !short_detect) [*4] |-> !converter_inhibit)
        else $error("converter inhibited with no fault");
    chk_strobe_end:
    assert property (@(posedge clk) disable iff (!rst_b) $fell(strobe_pin) |-> ##[1:5] !flash_on)
        else $error("flash kept on after strobe fell");
    chk_flash_cap:
    assert property (@(posedge clk) disable iff (!rst_b) flash_run <= run_cap)
        else $error("flash outlasted the time-out limit");
    chk_write_busy:
    assert property (@(posedge link_clk) disable iff (!rst_b)
        link_wr_valid && !link_busy |=> link_busy)
        else $error("data byte not taken while idle");
    chk_read_pulse:
    assert property (@(posedge link_clk) disable iff (!rst_b) link_rd_valid |=> !link_rd_valid)
        else $error("read valid longer than one cycle");
    ////////////////////////////////////////
    cover property (@(posedge clk) disable iff (!rst_b) $rose(flash_on));
    cover property (@(posedge clk) disable iff (!rst_b) $rose(converter_inhibit));
    cover property (@(posedge clk) disable iff (!rst_b) $rose(torch_on));
    cover property (@(posedge link_clk) disable iff (!rst_b) link_rd_valid);
endmodule // flash_regs_asserts
bind flash_led_driver_register_bank flash_regs_asserts #(.clk_per_ms(clk_per_ms))
    flash_regs_asserts_i (.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
    .link_wr_valid(link_wr_valid), .link_rd_valid(link_rd_valid), .link_busy(link_busy),
    .strobe_pin(strobe_pin), .short_detect(short_detect), .overheat_detect(overheat_detect),
    .overvoltage_detect(overvoltage_detect), .main_current_code(main_current_code),
    .torch_on(torch_on), .flash_armed(flash_armed), .flash_on(flash_on),
    .converter_inhibit(converter_inhibit));
`default_nettype wire

/* tb/link_host.sv */
// host side of the byte link: subaddress, write and read pulses
// assumes the bank samples pulses on rising link_clk while link_busy is low
`timescale 1ns/1ns
`default_nettype none
module link_host (
    output logic            link_clk,
    output logic            link_sub_valid,
    output logic            link_wr_valid,
    output logic            link_rd_req,
    output logic      [7:0] link_byte,
    input  wire logic [7:0] link_rd_data,
    input  wire logic       link_rd_valid,
    input  wire logic       link_busy
);
    ////////////////////////////////////////
    logic run = 1'b1;
    initial
    begin
        link_clk = 1'b0;
        {link_sub_valid, link_wr_valid, link_rd_req} = 3'h0;
        link_byte = 8'h5a;
    end
    // clock parks low between transfers
    always #80 if (run || link_clk) link_clk = ~link_clk;
    ////////////////////////////////////////
    // k: 0 subaddress, 1 write byte, 2 read byte
    task automatic xfer(input int k, input logic [7:0] b, output logic [7:0] d);
        int n;
        run = 1'b1;
        @(posedge link_clk);
        #1 {link_sub_valid, link_wr_valid, link_rd_req} = 3'(3'h4 >> k);
        link_byte = b;
        @(posedge link_clk);
        #1 {link_sub_valid, link_wr_valid, link_rd_req} = 3'h0;
        // released byte lines show the inverse, never the last value
        link_byte = ~b;
        for (n = 0; n < 30 && (n < 3 || link_busy); n++)
        begin
            @(posedge link_clk);
            if (link_rd_valid)
                d = link_rd_data;
        end
        repeat (2) @(posedge link_clk);
        run = 1'b0;
    endtask
endmodule // link_host
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench for the flash register bank
// assumes link_host as the serial host and a shortened millisecond count
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin miscompares++; \
    $display("BAD %s exp %h got %h", n, e, s); end end
module testbench;
    localparam int cpm = 10;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       strobe_pin = 1'b0;
    logic [2:0] fl = 3'h0;
    wire        link_clk, link_sub_valid, link_wr_valid, link_rd_req, link_rd_valid, link_busy;
    wire  [7:0] link_byte, link_rd_data;
    wire  [4:0] main_current_code;
    wire  [2:0] indicator_current_code;
    wire        torch_on, flash_armed, flash_on, converter_inhibit;
    int         tests_run = 0, miscompares = 0, cyc = 0, i, n;
    logic [7:0] d;
    logic [4:0] m;
    logic [4:0] mc [5] = '{5'h00, 5'h01, 5'h0b, 5'h0c, 5'h1f};
    logic [2:0] ic [5] = '{3'h1, 3'h3, 3'h7, 3'h0, 3'h7};
    logic [7:0] bx [5] = '{8'h60, 8'h1f, 8'h00, 8'h00, 8'h00};
    logic [7:0] tc [3] = '{8'h1f, 8'h1e, 8'h0f};
    logic [7:0] ts [3] = '{8'h00, 8'h00, 8'h02};
    int         tm [3] = '{1, 56, 820};
    ////////////////////////////////////////
    always #50 clk = ~clk;
    flash_led_driver_register_bank #(.clk_per_ms(cpm)) flash_led_driver_register_bank_i (
        .clk(clk), .rst_b(rst_b), .link_clk(link_clk), .link_sub_valid(link_sub_valid),
        .link_wr_valid(link_wr_valid), .link_rd_req(link_rd_req), .link_byte(link_byte),
        .link_rd_data(link_rd_data), .link_rd_valid(link_rd_valid), .link_busy(link_busy),
        .strobe_pin(strobe_pin), .short_detect(fl[2]), .overheat_detect(fl[1]),
        .overvoltage_detect(fl[0]), .main_current_code(main_current_code),
        .indicator_current_code(indicator_current_code), .torch_on(torch_on),
        .flash_armed(flash_armed), .flash_on(flash_on), .converter_inhibit(converter_inhibit));
    link_host link_host_i (.link_clk(link_clk), .link_sub_valid(link_sub_valid),
        .link_wr_valid(link_wr_valid), .link_rd_req(link_rd_req), .link_byte(link_byte),
        .link_rd_data(link_rd_data), .link_rd_valid(link_rd_valid), .link_busy(link_busy));
    ////////////////////////////////////////
    task automatic results;
        $display("checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        logic [7:0] x;
        link_host_i.xfer(0, a, x);
        link_host_i.xfer(1, v, x);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        logic [7:0] x;
        link_host_i.xfer(0, a, x);
        link_host_i.xfer(2, 8'h00, x);
        `CHK("rd", e, x)
    endtask
    task automatic flash_len(output int k);
        k = 0;
        while (flash_on !== 1'b1 && k < 50)
        begin
            @(posedge clk);
            k++;
        end
        k = 0;
        while (flash_on === 1'b1 && k < 9000)
        begin
            @(posedge clk);
            k++;
        end
    endtask
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            miscompares++;
            results();
        end
    end
    ////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge clk);
        #1 rst_b = 1'b1;
        repeat (5) @(posedge clk);
        `CHK("off", 1'b0, torch_on | flash_armed | flash_on)
        for (i = 0; i < 4; i++)
            rd(i[7:0], 8'h00);
        for (i = 0; i < 5; i++)
        begin
            m = mc[i];
            wr(8'h00, {m, ic[i]});
            repeat (4) @(posedge clk);
            `CHK("main", m, main_current_code)
            `CHK("ind", ic[i], indicator_current_code)
            `CHK("torch", m >= 5'h01 && m <= 5'h0b, torch_on)
            `CHK("armed", m >= 5'h0c, flash_armed)
            `CHK("idle", 1'b0, flash_on)
            rd(8'h00, {m, ic[i]});
        end
        link_host_i.xfer(0, 8'h00, d);
        link_host_i.xfer(1, 8'h60, d);
        link_host_i.xfer(1, 8'hff, d);
        link_host_i.xfer(1, 8'h00, d);
        link_host_i.xfer(0, 8'h00, d);
        for (i = 0; i < 5; i++)
        begin
            link_host_i.xfer(2, 8'h00, d);
            `CHK("burst", bx[i], d)
        end
        wr(8'h03, 8'hff);
        rd(8'h03, 8'h00);
        for (i = 0; i < 3; i++)
        begin
            wr(8'h01, tc[i]);
            @(posedge clk);
            #1 strobe_pin = 1'b1;
            flash_len(n);
            `CHK("len", 1'b1, n >= tm[i] * cpm - 2 && n <= tm[i] * cpm + 15)
            @(posedge clk);
            #1 strobe_pin = 1'b0;
            rd(8'h03, ts[i]);
        end
        wr(8'h01, 8'h10);
        wr(8'h02, 8'h01);
        repeat (4) @(posedge clk);
        `CHK("trig", 1'b1, flash_on)
        rd(8'h03, 8'h00);
        rd(8'h02, 8'h01);
        @(posedge clk);
        #1 strobe_pin = 1'b1;
        repeat (3) @(posedge clk);
        #1 strobe_pin = 1'b0;
        repeat (5) @(posedge clk);
        `CHK("end", 1'b0, flash_on)
        rd(8'h02, 8'h00);
        for (i = 0; i <= 3; i++)
        begin
            @(posedge clk);
            #1 fl = (i < 3) ? 3'(1 << i) : 3'h0;
            repeat (5) @(posedge clk);
            `CHK("inhibit", i < 3, converter_inhibit)
            rd(8'h03, {4'h0, fl[2], fl[1], 1'b0, fl[0]});
        end
        results();
    end
endmodule // testbench
`default_nettype wire
